// file: design/dap_drive_ctrl.sv
// Access arbitration, movement range and position scaling of the drive
`timescale 1ns/1ps
`default_nettype none
module dap_drive_ctrl
	import dap_pkg::*;
(
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	// Fieldbus parameter port
	input  wire logic        par_wr_i,
	input  wire logic        par_rd_i,
	input  wire logic        par_src_i,
	input  wire logic [15:0] par_addr_i,
	input  wire logic [31:0] par_wdata_i,
	output logic      [31:0] par_rdata_o,
	output logic             par_ack_o,
	output logic             par_err_o,
	// Drive state and tool switch
	input  wire logic        tool_excl_i,
	input  wire logic        ps_enabled_i,
	// Inputs that no lock can block
	input  wire logic        stop_i,
	input  wire logic        fault_clr_i,
	input  wire logic        enable_i,
	input  wire logic        positive_end_switch_i,
	input  wire logic        negative_end_switch_i,
	input  wire logic        home_switch_i,
	input  wire logic        safe_torque_off_a_n_i,
	input  wire logic        safe_torque_off_b_n_i,
	// Lockable jog inputs
	input  wire logic        in_jog_pos_i,
	input  wire logic        in_jog_neg_i,
	input  wire logic        in_jog_fast_i,
	// Motion progress and movement commands
	input  wire logic        motion_valid_i,
	input  wire logic [31:0] motion_delta_i,
	input  wire logic        cmd_valid_i,
	input  wire logic [1:0]  cmd_src_i,
	input  wire logic [1:0]  cmd_kind_i,
	input  wire logic [31:0] cmd_value_i,
	// Unit conversion
	input  wire logic        conv_req_i,
	input  wire logic        conv_to_usr_i,
	input  wire logic [31:0] conv_val_i,
	// Safety and control outputs
	output logic             stop_o,
	output logic             fault_clr_o,
	output logic             enable_o,
	output logic             positive_end_switch_o,
	output logic             negative_end_switch_o,
	output logic             home_switch_o,
	output logic             safe_torque_off_a_n_o,
	output logic             safe_torque_off_b_n_o,
	output logic             jog_pos_o,
	output logic             jog_neg_o,
	output logic             jog_fast_o,
	// Status outputs
	output logic      [2:0]  owner_o,
	output logic      [31:0] position_o,
	output logic             zero_valid_o,
	output logic             range_wrap_o,
	output logic             cmd_accept_o,
	output logic             cmd_refuse_o,
	output logic      [31:0] cmd_target_o,
	output logic             conv_busy_o,
	output logic             conv_done_o,
	output logic      [31:0] conv_res_o
);
	typedef struct packed {
		logic [15:0]          lock;
		logic [31:0]          den_pend;
		logic [31:0]          num;
		logic [31:0]          den;
		dap_owner_e           owner;
		logic [31:0]          pos;
		logic                 zero_valid;
		logic                 wrapped;
		logic [31:0]          par_rdata;
		logic                 par_ack;
		logic                 par_err;
		logic                 cmd_acc;
		logic                 cmd_ref;
		logic [31:0]          cmd_tgt;
		logic [7:0]           safe;
		logic [2:0]           jog;
		dap_conv_e            cv;
		logic                 cv_neg;
		logic [31:0]          conv_res;
		logic                 conv_done;
		logic                 div_start;
		logic [DAP_DVD_W-1:0] dividend;
		logic [DAP_DVS_W-1:0] divisor;
	} dap_ctrl_s;

	localparam dap_ctrl_s DAP_CTRL_RST = '{
		lock:     DAP_LOCK_RST,
		den_pend: DAP_DENOM_RST,
		num:      DAP_NUM_RST,
		den:      DAP_DENOM_RST,
		owner:    DAP_OWN_NONE,
		cv:       DAP_CV_IDLE,
		divisor:  {16'h0000, DAP_DENOM_RST},
		default:  '0
	};

	dap_ctrl_s r;
	dap_ctrl_s n;

	dap_div_if div ();

	dap_divider u_divider (
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.div     (div.slv)
	);

	// True when a 33-bit sum lies in the 31-bit movement range
	function automatic logic dap_fits(input logic [32:0] v);
		dap_fits = (v[32:30] == 3'b000) || (v[32:30] == 3'b111);
	endfunction : dap_fits

	always_comb begin
		logic                 bus_ok;
		logic                 tool_ok;
		logic                 in_ok;
		logic                 src_ok;
		logic                 wr_ok;
		logic                 scale_ok;
		logic                 small_scale;
		logic [DAP_DVS_W-1:0] factor;
		logic [32:0]          sum;
		logic [32:0]          tgt;
		logic [32:0]          val;
		logic [31:0]          mag;
		logic [31:0]          clip;
		bus_ok = 1'b0;
		tool_ok = 1'b0;
		in_ok = 1'b0;
		src_ok = 1'b0;
		wr_ok = 1'b0;
		scale_ok = 1'b0;
		small_scale = 1'b0;
		factor = '0;
		sum = '0;
		tgt = '0;
		val = '0;
		mag = '0;
		clip = '0;
		n = r;
		n.par_ack = 1'b0;
		n.par_err = 1'b0;
		n.cmd_acc = 1'b0;
		n.cmd_ref = 1'b0;
		n.conv_done = 1'b0;
		n.div_start = 1'b0;
		n.wrapped = 1'b0;

		bus_ok = r.owner != DAP_OWN_TOOL;
		tool_ok = r.owner != DAP_OWN_BUS;
		in_ok = r.owner == DAP_OWN_NONE;
		// Increments per user unit numerator: revolutions times 32768
		factor = {2'b00, r.num[30:0], DAP_INC_PAD};
		small_scale = factor < {17'h00000, r.den[30:0]};
		scale_ok = !par_wdata_i[31] && (par_wdata_i != 32'h0000_0000);

		// Safety inputs never gated by the lock or by exclusive access; jog passes only with no owner
		n.safe = {stop_i, fault_clr_i, enable_i, positive_end_switch_i,
			negative_end_switch_i, home_switch_i,
			safe_torque_off_a_n_i, safe_torque_off_b_n_i};
		n.jog = in_ok ? {in_jog_pos_i, in_jog_neg_i, in_jog_fast_i}
			: 3'h0;

		// Parameter port; only the fieldbus may write the lock
		wr_ok = par_src_i ? tool_ok : bus_ok;
		if (par_rd_i) begin
			n.par_ack = 1'b1;
			if (par_addr_i == DAP_OFS_LOCK) begin
				n.par_rdata = {16'h0000, r.lock};
			end else if (par_addr_i == DAP_OFS_DENOM) begin
				n.par_rdata = r.den_pend;
			end else if (par_addr_i == DAP_OFS_NUM) begin
				n.par_rdata = r.num;
			end else begin
				n.par_rdata = 32'h0000_0000;
				n.par_err = 1'b1;
			end
		end else if (par_wr_i) begin
			n.par_ack = 1'b1;
			if (!wr_ok) begin
				n.par_err = 1'b1;
			end else if (par_addr_i == DAP_OFS_LOCK) begin
				if (par_src_i || par_wdata_i[31:16] != 16'h0000) begin
					n.par_err = 1'b1;
				end else if (par_wdata_i[15:0] == DAP_LOCK_OPEN) begin
					n.lock = DAP_LOCK_OPEN;
				end else if (par_wdata_i[15:0] == DAP_LOCK_SET) begin
					n.lock = DAP_LOCK_SET;
				end else begin
					n.par_err = 1'b1;
				end
			end else if (par_addr_i == DAP_OFS_DENOM
				|| par_addr_i == DAP_OFS_NUM) begin
				if (ps_enabled_i || !scale_ok) begin
					n.par_err = 1'b1;
				end else if (par_addr_i == DAP_OFS_DENOM) begin
					n.den_pend = par_wdata_i;
				end else begin
					n.num = par_wdata_i;
					n.den = r.den_pend;
				end
			end else begin
				n.par_err = 1'b1;
			end
		end

		// Ownership follows the lock first, then the tool switch
		if (n.lock == DAP_LOCK_SET) begin
			n.owner = DAP_OWN_BUS;
		end else if (tool_excl_i) begin
			n.owner = DAP_OWN_TOOL;
		end else begin
			n.owner = DAP_OWN_NONE;
		end

		// Reported motion; range is 31-bit two's complement
		sum = {r.pos[31], r.pos} + {motion_delta_i[31], motion_delta_i};
		if (motion_valid_i) begin
			if (dap_fits(sum)) begin
				n.pos = sum[31:0];
			end else begin
				n.zero_valid = 1'b0;
				if (small_scale) begin
					n.pos = r.pos[31] ? DAP_RANGE_MIN : DAP_RANGE_MAX;
				end else begin
					n.pos = {sum[30], sum[30:0]};
					n.wrapped = 1'b1;
				end
			end
		end

		// Commands come after motion so that a homing set wins
		tgt = {r.pos[31], r.pos} + {cmd_value_i[31], cmd_value_i};
		val = {cmd_value_i[31], cmd_value_i};
		case (cmd_src_i)
			DAP_SRC_BUS:   src_ok = bus_ok;
			DAP_SRC_TOOL:  src_ok = tool_ok;
			DAP_SRC_INPUT: src_ok = in_ok;
			default:       src_ok = 1'b0;
		endcase
		if (cmd_valid_i) begin
			if (!src_ok) begin
				n.cmd_ref = 1'b1;
			end else if (cmd_kind_i == DAP_MV_STEP
				|| cmd_kind_i == DAP_MV_REL) begin
				if (dap_fits(tgt)) begin
					n.cmd_acc = 1'b1;
					n.cmd_tgt = tgt[31:0];
				end else if (small_scale || !dap_fits(val)) begin
					n.cmd_ref = 1'b1;
				end else begin
					n.pos = 32'h0000_0000;
					n.zero_valid = 1'b0;
					n.cmd_acc = 1'b1;
					n.cmd_tgt = cmd_value_i;
				end
			end else if (!dap_fits(val)) begin
				n.cmd_ref = 1'b1;
			end else begin
				n.cmd_acc = 1'b1;
				n.cmd_tgt = cmd_value_i;
				if (cmd_kind_i == DAP_MV_HOME) begin
					n.pos = cmd_value_i;
					n.zero_valid = 1'b1;
				end
			end
		end

		// Unit conversion through the divider
		mag = conv_val_i[31] ? 32'h0000_0000 - conv_val_i : conv_val_i;
		clip = (div.quotient[DAP_DVD_W-1:31] != '0) ? DAP_SCALE_MAX
			: div.quotient[31:0];
		case (r.cv)
			DAP_CV_IDLE: begin
				if (conv_req_i) begin
					n.cv = DAP_CV_RUN;
					n.cv_neg = conv_val_i[31];
					n.div_start = 1'b1;
					if (conv_to_usr_i) begin
						n.dividend = {48'h0, mag} * {48'h0, r.den};
						n.divisor = factor;
					end else begin
						n.dividend = {48'h0, mag} * {32'h0, factor};
						n.divisor = {16'h0000, r.den};
					end
				end
			end
			DAP_CV_RUN: begin
				if (div.done) begin
					n.cv = DAP_CV_IDLE;
					n.conv_done = 1'b1;
					n.conv_res = r.cv_neg ? 32'h0000_0000 - clip : clip;
				end
			end
			default: begin
				n.cv = DAP_CV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= DAP_CTRL_RST;
		end else begin
			r <= n;
		end
	end

	assign div.start    = r.div_start;
	assign div.dividend = r.dividend;
	assign div.divisor  = r.divisor;

	assign par_rdata_o           = r.par_rdata;
	assign par_ack_o             = r.par_ack;
	assign par_err_o             = r.par_err;
	assign stop_o                = r.safe[7];
	assign fault_clr_o           = r.safe[6];
	assign enable_o              = r.safe[5];
	assign positive_end_switch_o = r.safe[4];
	assign negative_end_switch_o = r.safe[3];
	assign home_switch_o         = r.safe[2];
	assign safe_torque_off_a_n_o = r.safe[1];
	assign safe_torque_off_b_n_o = r.safe[0];
	assign jog_pos_o             = r.jog[2];
	assign jog_neg_o             = r.jog[1];
	assign jog_fast_o            = r.jog[0];
	assign owner_o               = r.owner;
	assign position_o            = r.pos;
	assign zero_valid_o          = r.zero_valid;
	assign range_wrap_o          = r.wrapped;
	assign cmd_accept_o          = r.cmd_acc;
	assign cmd_refuse_o          = r.cmd_ref;
	assign cmd_target_o          = r.cmd_tgt;
	assign conv_busy_o           = r.cv[1];
	assign conv_done_o           = r.conv_done;
	assign conv_res_o            = r.conv_res;
endmodule : dap_drive_ctrl
`default_nettype wire

// file: pkg/dap_pkg.sv
// Constants and types of the drive access and position scaling block
package dap_pkg;
	// Parameter offsets on the fieldbus parameter port
	localparam logic [15:0] DAP_OFS_LOCK  = 16'h013c;
	localparam logic [15:0] DAP_OFS_DENOM = 16'h060e;
	localparam logic [15:0] DAP_OFS_NUM   = 16'h0610;

	// Reset and legal values
	localparam logic [15:0] DAP_LOCK_RST  = 16'h0000;
	localparam logic [15:0] DAP_LOCK_OPEN = 16'h0000;
	localparam logic [15:0] DAP_LOCK_SET  = 16'h0001;
	localparam logic [31:0] DAP_DENOM_RST = 32'h0000_4000;
	localparam logic [31:0] DAP_NUM_RST   = 32'h0000_0001;
	localparam logic [31:0] DAP_SCALE_MAX = 32'h7fff_ffff;

	// 32768 increments per revolution, as a shift
	localparam logic [14:0] DAP_INC_PAD   = 15'h0000;

	// Movement range in user units
	localparam logic [31:0] DAP_RANGE_MIN = 32'hc000_0000;
	localparam logic [31:0] DAP_RANGE_MAX = 32'h3fff_ffff;

	// Divider geometry
	localparam int          DAP_DVD_W     = 80;
	localparam int          DAP_DVS_W     = 48;
	localparam logic [6:0]  DAP_DIV_STEPS = 7'h50;

	// Command sources
	localparam logic [1:0]  DAP_SRC_BUS   = 2'h0;
	localparam logic [1:0]  DAP_SRC_TOOL  = 2'h1;
	localparam logic [1:0]  DAP_SRC_INPUT = 2'h2;

	// Movement command kinds
	localparam logic [1:0]  DAP_MV_STEP   = 2'h0;
	localparam logic [1:0]  DAP_MV_REL    = 2'h1;
	localparam logic [1:0]  DAP_MV_ABS    = 2'h2;
	localparam logic [1:0]  DAP_MV_HOME   = 2'h3;

	typedef enum logic [2:0] {
		DAP_OWN_NONE = 3'b001,
		DAP_OWN_BUS  = 3'b010,
		DAP_OWN_TOOL = 3'b100
	} dap_owner_e;

	typedef enum logic [1:0] {
		DAP_CV_IDLE = 2'b01,
		DAP_CV_RUN  = 2'b10
	} dap_conv_e;
endpackage : dap_pkg

// file: pkg/dap_div_if.sv
// Handshake between the controller and its divider
`timescale 1ns/1ps
`default_nettype none
interface dap_div_if;
	import dap_pkg::*;
	logic                 start;
	logic [DAP_DVD_W-1:0] dividend;
	logic [DAP_DVS_W-1:0] divisor;
	logic                 done;
	logic [DAP_DVD_W-1:0] quotient;
	modport mst (output start, dividend, divisor, input done, quotient);
	modport slv (input start, dividend, divisor, output done, quotient);
endinterface : dap_div_if
`default_nettype wire

// file: design/dap_divider.sv
// Sequential restoring divider for unit conversion
`timescale 1ns/1ps
`default_nettype none
module dap_divider
	import dap_pkg::*;
(
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic nrst_i,
	// Controller side
	dap_div_if.slv    div
);
	typedef struct packed {
		logic [DAP_DVD_W-1:0] quo;
		logic [DAP_DVS_W:0]   rem;
		logic [6:0]           cnt;
		logic                 busy;
		logic                 done;
	} dap_div_s;

	dap_div_s r;
	dap_div_s n;

	always_comb begin
		logic [DAP_DVS_W:0] sh;
		sh = '0;
		n = r;
		n.done = 1'b0;
		if (div.start) begin
			n.quo = div.dividend;
			n.rem = '0;
			n.cnt = DAP_DIV_STEPS;
			n.busy = 1'b1;
		end else if (r.busy) begin
			sh = {r.rem[DAP_DVS_W-1:0], r.quo[DAP_DVD_W-1]};
			// Divisor is held steady by the controller during a run
			if (sh >= {1'b0, div.divisor}) begin
				n.rem = sh - {1'b0, div.divisor};
				n.quo = {r.quo[DAP_DVD_W-2:0], 1'b1};
			end else begin
				n.rem = sh;
				n.quo = {r.quo[DAP_DVD_W-2:0], 1'b0};
			end
			n.cnt = r.cnt - 7'h01;
			if (r.cnt == 7'h01) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign div.done     = r.done;
	assign div.quotient = r.quo;
endmodule : dap_divider
`default_nettype wire

// file: verification/dap_properties.sv
// Concurrent checks of the access and scaling controller
`timescale 1ns/1ps
`default_nettype none
module dap_properties
	import dap_pkg::*;
(
	// Clock and reset
	input wire logic        clock_i, nrst_i,
	// Parameter port
	input wire logic        par_wr_i, par_rd_i, par_src_i, ps_enabled_i,
	input wire logic [15:0] par_addr_i,
	input wire logic [31:0] par_wdata_i,
	input wire logic        par_ack_o, par_err_o,
	// Pass-through and jog
	input wire logic        stop_i, stop_o, in_jog_pos_i, jog_pos_o,
	input wire logic        safe_torque_off_a_n_i, safe_torque_off_a_n_o,
	// Status, commands and conversion
	input wire logic [2:0]  owner_o,
	input wire logic        zero_valid_o, cmd_valid_i, cmd_refuse_o,
	input wire logic [1:0]  cmd_kind_i,
	input wire logic [31:0] cmd_value_i,
	input wire logic        conv_req_i, conv_busy_o, conv_done_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	sequence conv_take;
		conv_req_i && !conv_busy_o;
	endsequence
	sequence conv_finish;
		conv_busy_o [*8] ##75 conv_done_o;
	endsequence
	// Past guard: the cycle before release still sees reset values
	stop_pass_a: assert property ($past(nrst_i) |->
		stop_o == $past(stop_i)) else $error("stop output lost input");
	sto_pass_a: assert property ($past(nrst_i) |->
		safe_torque_off_a_n_o == $past(safe_torque_off_a_n_i))
		else $error("torque-off output lost input");
	one_owner_a: assert property ($onehot(owner_o))
		else $error("owner not one-hot");
	power_up_a: assert property ($rose(nrst_i) |->
		owner_o == DAP_OWN_NONE) else $error("owner held after reset");
	lock_take_a: assert property (par_wr_i && !par_rd_i && !par_src_i
		&& par_addr_i == DAP_OFS_LOCK && par_wdata_i == 32'h1
		&& owner_o == DAP_OWN_NONE |=> owner_o == DAP_OWN_BUS)
		else $error("lock did not give bus ownership");
	lock_value_a: assert property (par_wr_i && !par_rd_i
		&& par_addr_i == DAP_OFS_LOCK && par_wdata_i > 32'h1
		|=> par_err_o) else $error("bad lock value taken");
	jog_block_a: assert property (owner_o == DAP_OWN_BUS ##1
		owner_o == DAP_OWN_BUS |-> !jog_pos_o) else $error("jog passed");
	scale_gate_a: assert property (par_wr_i && !par_rd_i && ps_enabled_i
		&& (par_addr_i == DAP_OFS_NUM || par_addr_i == DAP_OFS_DENOM)
		|=> par_ack_o && par_err_o) else $error("scaling write taken");
	abs_refuse_a: assert property (cmd_valid_i
		&& cmd_kind_i == DAP_MV_ABS
		&& ($signed(cmd_value_i) > $signed(DAP_RANGE_MAX)
		|| $signed(cmd_value_i) < $signed(DAP_RANGE_MIN))
		|=> cmd_refuse_o) else $error("absolute move not refused");
	zero_cause_a: assert property ($rose(zero_valid_o) |->
		$past(cmd_valid_i) && $past(cmd_kind_i) == DAP_MV_HOME)
		else $error("zero valid without homing");
	conv_time_a: assert property (conv_take |=> conv_finish)
		else $error("conversion timing wrong");
endmodule : dap_properties
bind dap_drive_ctrl dap_properties chk (.*);
`default_nettype wire

// file: verification/dap_master.sv
// Fieldbus master model driving the parameter port
`timescale 1ns/1ps
`default_nettype none
module dap_master (
	// Clock
	input  wire logic        clock_i,
	// Request side
	output var logic         wr_o, rd_o, src_o,
	output var logic  [15:0] addr_o,
	output var logic  [31:0] wdata_o,
	// Answer side
	input  wire logic        ack_i, err_i,
	input  wire logic [31:0] rdata_i
);
	initial begin
		{wr_o, rd_o, src_o, addr_o, wdata_o} = '0;
	end
	// One-cycle strobe; answer read in the cycle it stands
	task automatic acc(input logic rd, s, input logic [15:0] a,
		input logic [31:0] d, output logic k, e, output logic [31:0] q);
		@(posedge clock_i);
		#1;
		{rd_o, wr_o, src_o, addr_o, wdata_o} = {rd, !rd, s, a, d};
		@(posedge clock_i);
		#1;
		{rd_o, wr_o} = 2'h0;
		wdata_o = ~d;
		{k, e, q} = {ack_i, err_i, rdata_i};
	endtask : acc
endmodule : dap_master
`default_nettype wire

// file: verification/dap_drive_ctrl_bench.sv
// Self-checking bench of the access and scaling controller
`timescale 1ns/1ps
`default_nettype none
module dap_drive_ctrl_bench;
	import dap_pkg::*;
	logic        clock_i, nrst_i, par_wr_i, par_rd_i, par_src_i;
	logic [15:0] par_addr_i;
	logic [31:0] par_wdata_i, par_rdata_o, motion_delta_i, cmd_value_i;
	logic [31:0] conv_val_i, position_o, cmd_target_o, conv_res_o, q;
	logic        par_ack_o, par_err_o, tool_excl_i, ps_enabled_i, stop_i;
	logic        fault_clr_i, enable_i, positive_end_switch_i, home_switch_i;
	logic        negative_end_switch_i, safe_torque_off_a_n_i, k, e;
	logic        safe_torque_off_b_n_i, in_jog_pos_i, in_jog_neg_i;
	logic        in_jog_fast_i, motion_valid_i, cmd_valid_i, conv_req_i;
	logic        conv_to_usr_i, stop_o, fault_clr_o, enable_o, home_switch_o;
	logic        positive_end_switch_o, negative_end_switch_o, jog_pos_o;
	logic        safe_torque_off_a_n_o, safe_torque_off_b_n_o, jog_neg_o;
	logic        jog_fast_o, zero_valid_o, range_wrap_o, cmd_accept_o;
	logic        cmd_refuse_o, conv_busy_o, conv_done_o;
	logic [1:0]  cmd_src_i, cmd_kind_i;
	logic [2:0]  owner_o, jog;
	logic [7:0]  pass;
	int          n_fail = 0;
	int          checks_done = 0;
	typedef struct packed {
		logic        rd, src;
		logic [15:0] addr;
		logic [31:0] data;
		logic        err;
		logic [31:0] rdata;
	} dap_row_s;
	dap_row_s rows [11];
	assign {stop_i, fault_clr_i, enable_i, positive_end_switch_i,
		negative_end_switch_i, home_switch_i, safe_torque_off_a_n_i,
		safe_torque_off_b_n_i} = pass;
	assign {in_jog_pos_i, in_jog_neg_i, in_jog_fast_i} = jog;
	initial begin
		clock_i = 1'h0;
		forever #12.5 clock_i = ~clock_i;
	end
	dap_drive_ctrl DUT (.*);
	dap_master bus_m (.clock_i(clock_i), .wr_o(par_wr_i), .rd_o(par_rd_i),
		.src_o(par_src_i), .addr_o(par_addr_i), .wdata_o(par_wdata_i),
		.ack_i(par_ack_o), .err_i(par_err_o), .rdata_i(par_rdata_o));
	task automatic chk_bit(input logic got, exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t bit %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_word(input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic results;
		$display("Checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results
	task automatic par(input logic s, input logic [15:0] a,
		input logic [31:0] d, input logic x);
		bus_m.acc(1'h0, s, a, d, k, e, q);
		chk_bit(k, 1'h1);
		chk_bit(e, x);
	endtask : par
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : tick
	task automatic cmd(input logic [1:0] s, kd, input logic [31:0] v,
		input logic ok);
		tick(1);
		{cmd_valid_i, cmd_src_i, cmd_kind_i, cmd_value_i} = {1'h1, s, kd, v};
		tick(1);
		cmd_valid_i = 1'h0;
		chk_bit(cmd_accept_o, ok);
		chk_bit(cmd_refuse_o, !ok);
	endtask : cmd
	task automatic move(input logic [31:0] p, input logic w);
		tick(1);
		{motion_valid_i, motion_delta_i} = {1'h1, 32'h20};
		tick(1);
		motion_valid_i = 1'h0;
		chk_word(position_o, p);
		chk_bit(range_wrap_o, w);
	endtask : move
	task automatic conv(input logic u, input logic [31:0] v, x);
		tick(1);
		{conv_req_i, conv_to_usr_i, conv_val_i} = {1'h1, u, v};
		tick(1);
		conv_req_i = 1'h0;
		chk_bit(conv_busy_o, 1'h1);
		for (int i = 0; i < 100 && conv_done_o !== 1'h1; i++) tick(1);
		if (conv_done_o !== 1'h1) begin
			n_fail++;
			results();
		end else begin
			chk_word(conv_res_o, x);
		end
	endtask : conv
	initial begin
		{nrst_i, tool_excl_i, ps_enabled_i, pass, jog} = '0;
		{motion_valid_i, motion_delta_i, cmd_valid_i, cmd_src_i} = '0;
		{cmd_kind_i, cmd_value_i, conv_req_i, conv_to_usr_i, conv_val_i} = '0;
		rows = '{'{1'h1, 1'h0, DAP_OFS_LOCK, 32'h0, 1'h0, 32'h0},
			'{1'h1, 1'h0, DAP_OFS_DENOM, 32'h0, 1'h0, 32'h4000},
			'{1'h1, 1'h0, DAP_OFS_NUM, 32'h0, 1'h0, 32'h1},
			'{1'h1, 1'h0, 16'h0, 32'h0, 1'h1, 32'h0},
			'{1'h0, 1'h0, DAP_OFS_LOCK, 32'h2, 1'h1, 32'h0},
			'{1'h0, 1'h1, DAP_OFS_LOCK, 32'h1, 1'h1, 32'h0},
			'{1'h0, 1'h0, DAP_OFS_NUM, 32'h0, 1'h1, 32'h0},
			'{1'h0, 1'h0, DAP_OFS_NUM, 32'h8000_0000, 1'h1, 32'h0},
			'{1'h0, 1'h0, DAP_OFS_DENOM, 32'h8000, 1'h0, 32'h0},
			'{1'h1, 1'h0, DAP_OFS_DENOM, 32'h0, 1'h0, 32'h8000},
			'{1'h1, 1'h0, DAP_OFS_NUM, 32'h0, 1'h0, 32'h1}};
		tick(20);
		nrst_i = 1'h1;
		foreach (rows[i]) begin
			bus_m.acc(rows[i].rd, rows[i].src, rows[i].addr, rows[i].data,
				k, e, q);
			chk_bit(e, rows[i].err);
			if (rows[i].rd) chk_word(q, rows[i].rdata);
		end
		// Pending denominator must not yet affect conversion
		conv(1'h0, 32'h1, 32'h2);
		conv(1'h1, 32'hffff_fffb, 32'hffff_fffe);
		par(1'h0, DAP_OFS_NUM, 32'h1, 1'h0);
		conv(1'h0, 32'h3, 32'h3);
		conv(1'h0, 32'h8000_0000, 32'h8000_0001);
		ps_enabled_i = 1'h1;
		par(1'h0, DAP_OFS_DENOM, 32'h2, 1'h1);
		ps_enabled_i = 1'h0;
		par(1'h0, DAP_OFS_LOCK, 32'h1, 1'h0);
		chk_word({29'h0, owner_o}, {29'h0, DAP_OWN_BUS});
		{pass, jog} = {8'ha5, 3'h7};
		tick(2);
		chk_word({24'h0, stop_o, fault_clr_o, enable_o, positive_end_switch_o,
			negative_end_switch_o, home_switch_o, safe_torque_off_a_n_o,
			safe_torque_off_b_n_o}, 32'ha5);
		chk_word({29'h0, jog_pos_o, jog_neg_o, jog_fast_o}, 32'h0);
		par(1'h1, DAP_OFS_DENOM, 32'h4000, 1'h1);
		cmd(DAP_SRC_INPUT, DAP_MV_HOME, 32'h5, 1'h0);
		for (int kd = 0; kd < 2; kd++) begin
			cmd(DAP_SRC_BUS, DAP_MV_HOME, 32'h5, 1'h1);
			chk_bit(zero_valid_o, 1'h1);
			cmd(DAP_SRC_BUS, 2'(kd), 32'h3fff_fffc, 1'h1);
			chk_word(position_o, 32'h0);
			chk_word(cmd_target_o, 32'h3fff_fffc);
		end
		cmd(DAP_SRC_BUS, DAP_MV_ABS, 32'h4000_0000, 1'h0);
		cmd(DAP_SRC_BUS, DAP_MV_ABS, 32'hc000_0000, 1'h1);
		cmd(DAP_SRC_BUS, DAP_MV_HOME, 32'h3fff_fff0, 1'h1);
		move(32'hc000_0010, 1'h1);
		chk_bit(zero_valid_o, 1'h0);
		par(1'h0, DAP_OFS_LOCK, 32'h0, 1'h0);
		tool_excl_i = 1'h1;
		tick(2);
		chk_word({29'h0, owner_o}, {29'h0, DAP_OWN_TOOL});
		par(1'h0, DAP_OFS_DENOM, 32'h4000, 1'h1);
		tool_excl_i = 1'h0;
		tick(2);
		chk_word({29'h0, owner_o}, {29'h0, DAP_OWN_NONE});
		chk_word({29'h0, jog_pos_o, jog_neg_o, jog_fast_o}, 32'h7);
		// Scale below 1/32768 clamps instead of wrapping
		par(1'h0, DAP_OFS_DENOM, 32'h1_0000, 1'h0);
		par(1'h0, DAP_OFS_NUM, 32'h1, 1'h0);
		// Home position rewritten by the host after rescaling
		cmd(DAP_SRC_BUS, DAP_MV_HOME, 32'h3fff_fff0, 1'h1);
		move(32'h3fff_ffff, 1'h0);
		cmd(DAP_SRC_BUS, DAP_MV_REL, 32'h20, 1'h0);
		results();
	end
endmodule : dap_drive_ctrl_bench
`default_nettype wire
